// ==== core/diotc_pkg.sv ====
package diotc_pkg;
	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] DIOTC_DIR_OFS = 8'h00;
	localparam logic [7:0] DIOTC_OUT_OFS = 8'h04;
	localparam logic [7:0] DIOTC_IN_OFS = 8'h08;
	localparam logic [7:0] DIOTC_DRV_OFS = 8'h0C;
	localparam logic [7:0] DIOTC_FUNC_OFS = 8'h10;
	localparam logic [7:0] DIOTC_CNT_OFS = 8'h14;
	localparam logic [7:0] DIOTC_STAT_OFS = 8'h18;
	// ----------------------------------------------------------------
	// Field positions and sizes
	// ----------------------------------------------------------------
	localparam int DIOTC_WIDE_N = 8;
	localparam int DIOTC_NARROW_N = 4;
	localparam int DIOTC_LINES = 12;
	localparam int DIOTC_CNT_W = 32;
	localparam int DIOTC_DRV_WIDE_BIT = 0;
	localparam int DIOTC_DRV_NARROW_BIT = 1;
	localparam int DIOTC_FUNC_MODE_BIT = 0;
	localparam int DIOTC_FUNC_TRIG_EN_BIT = 1;
	localparam int DIOTC_FUNC_RISE_BIT = 2;
	localparam int DIOTC_FUNC_ARM_BIT = 3;
	localparam int DIOTC_FUNC_CLR_BIT = 4;
	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [11:0] DIOTC_DIR_RST = 12'h000;
	localparam logic [11:0] DIOTC_OUT_RST = 12'h000;
	localparam logic [1:0] DIOTC_DRV_RST = 2'h0;
	localparam logic [31:0] DIOTC_CNT_RST = 32'h00000000;

	typedef enum logic [1:0] {
		DIOTC_TRIG_IDLE = 2'b00,
		DIOTC_TRIG_WAIT = 2'b01,
		DIOTC_TRIG_RUN = 2'b10
	} diotc_trig_state_t;

	typedef struct packed {
		logic counter_mode;
		logic trig_enable;
		logic rising;
	} diotc_func_t;

	typedef struct packed {
		logic rise;
		logic fall;
	} diotc_edges_t;
endpackage

// ==== core/diotc_edge_sync.sv ====
`timescale 1ns/1ps
module diotc_edge_sync
	import diotc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pin,
	output diotc_edges_t edges,
	output logic level
);
	logic meta;
	logic sync;
	logic prev;

	// Only sync reads meta; edges come from sync and prev
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta <= 1'b1;
			sync <= 1'b1;
			prev <= 1'b1;
		end else begin
			meta <= pin; // R13
			sync <= meta;
			prev <= sync;
		end
	end

	assign edges.rise = sync & ~prev; // R13
	assign edges.fall = ~sync & prev;
	assign level = sync;

	property p_one_fall;
		@(posedge pclk) disable iff (!presetn)
		edges.fall |=> !edges.fall;
	endproperty
	a_one_fall: assert property (p_one_fall) else $error("falling edge seen twice"); // R13
endmodule

// ==== core/diotc_counter.sv ====
`timescale 1ns/1ps
module diotc_counter
	import diotc_pkg::*;
#(
	parameter int W = DIOTC_CNT_W
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clear,
	input wire logic inc,
	output logic [W-1:0] count
);
	logic [W-1:0] next_count;

	// Wraps naturally from all ones to zero; clear loses to nothing but reset
	assign next_count = clear ? '0 : (inc ? count + 1'b1 : count); // R10 R12

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= '0;
		end else begin
			count <= next_count;
		end
	end

	property p_count_inc;
		@(posedge pclk) disable iff (!presetn)
		inc && !clear |=> count == $past(count) + 1'b1;
	endproperty
	a_count_inc: assert property (p_count_inc) else $error("counter did not step"); // R10

	property p_count_wrap;
		@(posedge pclk) disable iff (!presetn)
		inc && !clear && (&count) |=> count == '0;
	endproperty
	a_count_wrap: assert property (p_count_wrap) else $error("counter did not wrap"); // R12
endmodule

// ==== core/diotc_top.sv ====
`timescale 1ns/1ps
// Overview of operation
// [R1] Twelve lines: wide port eight, narrow four
// [R2] Each line has its own direction bit
// [R3] Default output pulls low, else releases
// [R4] Per port active drive option
// [R5] Reset leaves every line undriven input
// [R6] Lines sampled and updated on software access
// [R7] Function pin is trigger or counter
// [R8] Trigger only while acquisition configured
// [R9] Start acquisition on selected edge
// [R10] Count falling edges in 32 bits
// [R11] Auxiliary supply off during suspend
// [R12] Counter wraps from all ones to zero
// [R13] Synchronise function pin before edge detection
module diotc_top
	import diotc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [DIOTC_WIDE_N-1:0] wide_port_lines_in,
	output logic [DIOTC_WIDE_N-1:0] wide_port_lines_out,
	output logic [DIOTC_WIDE_N-1:0] wide_port_lines_oe,
	input wire logic [DIOTC_NARROW_N-1:0] narrow_port_lines_in,
	output logic [DIOTC_NARROW_N-1:0] narrow_port_lines_out,
	output logic [DIOTC_NARROW_N-1:0] narrow_port_lines_oe,
	input wire logic trigger_counter_pin,
	input wire logic acq_configured,
	output logic acquisition_start_trigger,
	output logic acq_running,
	input wire logic usb_suspend,
	output logic aux_supply_enable
);
	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	wire bus_wr = psel & penable & pwrite;
	wire bus_rd = psel & penable & ~pwrite;
	wire hit_dir = paddr == DIOTC_DIR_OFS;
	wire hit_out = paddr == DIOTC_OUT_OFS;
	wire hit_in = paddr == DIOTC_IN_OFS;
	wire hit_drv = paddr == DIOTC_DRV_OFS;
	wire hit_func = paddr == DIOTC_FUNC_OFS;
	wire hit_cnt = paddr == DIOTC_CNT_OFS;
	wire hit_stat = paddr == DIOTC_STAT_OFS;
	wire hit_any = hit_dir | hit_out | hit_in | hit_drv | hit_func | hit_cnt | hit_stat;

	assign pready = 1'b1;
	assign pslverr = psel & penable & ~hit_any;

	// ----------------------------------------------------------------
	// Line registers
	// ----------------------------------------------------------------
	logic [DIOTC_LINES-1:0] dir;
	logic [DIOTC_LINES-1:0] out_val;
	logic [DIOTC_LINES-1:0] in_snap;
	logic [1:0] drive_mode;
	diotc_func_t func;
	logic arm_req;
	logic cnt_clear;

	wire [DIOTC_LINES-1:0] pins_in = {narrow_port_lines_in, wide_port_lines_in}; // R1

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dir <= DIOTC_DIR_RST; // R5
			out_val <= DIOTC_OUT_RST;
			drive_mode <= DIOTC_DRV_RST; // R3
			func <= '0;
		end else if (bus_wr) begin
			if (hit_dir) dir <= pwdata[DIOTC_LINES-1:0]; // R2
			if (hit_out) out_val <= pwdata[DIOTC_LINES-1:0]; // R6
			if (hit_drv) drive_mode <= pwdata[1:0]; // R4
			if (hit_func) begin
				func.counter_mode <= pwdata[DIOTC_FUNC_MODE_BIT]; // R7
				func.trig_enable <= pwdata[DIOTC_FUNC_TRIG_EN_BIT];
				func.rising <= pwdata[DIOTC_FUNC_RISE_BIT];
			end
		end
	end

	// Inputs are captured only when software reads the input register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			in_snap <= '0;
		end else if (bus_rd && hit_in) begin
			in_snap <= pins_in; // R6
		end
	end

	assign arm_req = bus_wr & hit_func & pwdata[DIOTC_FUNC_ARM_BIT];
	assign cnt_clear = bus_wr & hit_func & pwdata[DIOTC_FUNC_CLR_BIT];

	// ----------------------------------------------------------------
	// Pin drivers
	// ----------------------------------------------------------------
	logic [DIOTC_LINES-1:0] pin_out;
	logic [DIOTC_LINES-1:0] pin_oe;

	genvar gi;
	generate
		for (gi = 0; gi < DIOTC_LINES; gi++) begin : g_line
			localparam int PORT_BIT = (gi < DIOTC_WIDE_N) ? DIOTC_DRV_WIDE_BIT
				: DIOTC_DRV_NARROW_BIT;
			wire active = drive_mode[PORT_BIT];
			// Open collector: drive only the low level, pull-up does the rest
			assign pin_out[gi] = active ? out_val[gi] : 1'b0; // R3 R4
			assign pin_oe[gi] = dir[gi] & (active | ~out_val[gi]); // R2 R5
		end
	endgenerate

	assign wide_port_lines_out = pin_out[DIOTC_WIDE_N-1:0];
	assign wide_port_lines_oe = pin_oe[DIOTC_WIDE_N-1:0];
	assign narrow_port_lines_out = pin_out[DIOTC_LINES-1:DIOTC_WIDE_N];
	assign narrow_port_lines_oe = pin_oe[DIOTC_LINES-1:DIOTC_WIDE_N];

	// ----------------------------------------------------------------
	// Function pin
	// ----------------------------------------------------------------
	diotc_edges_t fp_edges;
	logic fp_level;
	logic [DIOTC_CNT_W-1:0] count;

	diotc_edge_sync u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.pin(trigger_counter_pin),
		.edges(fp_edges),
		.level(fp_level)
	);

	wire cnt_inc = func.counter_mode & fp_edges.fall; // R7 R10

	diotc_counter #(.W(DIOTC_CNT_W)) u_cnt (
		.pclk(pclk),
		.presetn(presetn),
		.clear(cnt_clear),
		.inc(cnt_inc),
		.count(count)
	);

	// ----------------------------------------------------------------
	// Start trigger sequencing
	// ----------------------------------------------------------------
	diotc_trig_state_t state;
	diotc_trig_state_t next_state;
	wire trig_ok = ~func.counter_mode & func.trig_enable & acq_configured; // R7 R8
	wire sel_edge = func.rising ? fp_edges.rise : fp_edges.fall; // R9

	always_comb begin
		next_state = state;
		case (state)
			DIOTC_TRIG_IDLE: begin
				if (arm_req && acq_configured) begin
					next_state = trig_ok ? DIOTC_TRIG_WAIT : DIOTC_TRIG_RUN;
				end
			end
			DIOTC_TRIG_WAIT: begin
				if (!acq_configured) next_state = DIOTC_TRIG_IDLE; // R8
				else if (sel_edge) next_state = DIOTC_TRIG_RUN; // R9
			end
			DIOTC_TRIG_RUN: begin
				if (!acq_configured) next_state = DIOTC_TRIG_IDLE;
			end
			default: next_state = DIOTC_TRIG_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= DIOTC_TRIG_IDLE;
			acquisition_start_trigger <= 1'b0;
		end else begin
			state <= next_state;
			acquisition_start_trigger <= (state != DIOTC_TRIG_RUN)
				&& (next_state == DIOTC_TRIG_RUN);
		end
	end

	assign acq_running = state == DIOTC_TRIG_RUN;

	// ----------------------------------------------------------------
	// Auxiliary supply
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			aux_supply_enable <= 1'b0;
		end else begin
			aux_supply_enable <= ~usb_suspend; // R11
		end
	end

	// ----------------------------------------------------------------
	// Read mux
	// ----------------------------------------------------------------
	wire [31:0] stat_word = {28'h0000000, fp_level, acq_running, state == DIOTC_TRIG_WAIT,
		aux_supply_enable};
	wire [31:0] rd_mux =
		hit_dir ? {20'h00000, dir} :
		hit_out ? {20'h00000, out_val} :
		hit_in ? {20'h00000, pins_in} :
		hit_drv ? {30'h00000000, drive_mode} :
		hit_func ? {29'h00000000, func.rising, func.trig_enable, func.counter_mode} :
		hit_cnt ? count :
		hit_stat ? stat_word : 32'h00000000;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (psel && !penable && !pwrite) begin
			prdata <= rd_mux;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	property p_input_undriven;
		@(posedge pclk) disable iff (!presetn)
		(dir == 12'h000) |-> (pin_oe == 12'h000);
	endproperty
	a_input_undriven: assert property (p_input_undriven) else $error("input line driven"); // R5

	property p_oc_no_high;
		@(posedge pclk) disable iff (!presetn)
		(drive_mode == 2'h0) |-> ((pin_oe & pin_out) == 12'h000);
	endproperty
	a_oc_no_high: assert property (p_oc_no_high) else $error("open collector drove high"); // R3

	property p_active_drive;
		@(posedge pclk) disable iff (!presetn)
		(drive_mode == 2'h3) |-> (pin_oe == dir) && ((pin_out & dir) == (out_val & dir));
	endproperty
	a_active_drive: assert property (p_active_drive) else $error("active drive wrong"); // R4

	property p_dir_write;
		@(posedge pclk) disable iff (!presetn)
		bus_wr && hit_dir |=> dir == $past(pwdata[DIOTC_LINES-1:0]);
	endproperty
	a_dir_write: assert property (p_dir_write) else $error("direction not stored"); // R2

	property p_trig_edge;
		@(posedge pclk) disable iff (!presetn)
		state == DIOTC_TRIG_WAIT && acq_configured && sel_edge |=> acquisition_start_trigger
			##1 !acquisition_start_trigger;
	endproperty
	a_trig_edge: assert property (p_trig_edge) else $error("trigger pulse missing"); // R9

	property p_trig_needs_acq;
		@(posedge pclk) disable iff (!presetn)
		!acq_configured |=> state != DIOTC_TRIG_WAIT;
	endproperty
	a_trig_needs_acq: assert property (p_trig_needs_acq) else $error("armed without task"); // R8

	property p_count_mode;
		@(posedge pclk) disable iff (!presetn)
		!func.counter_mode && !cnt_clear |=> count == $past(count);
	endproperty
	a_count_mode: assert property (p_count_mode) else $error("counted in trigger mode"); // R7

	property p_supply;
		@(posedge pclk) disable iff (!presetn)
		usb_suspend ##1 usb_suspend |-> !aux_supply_enable;
	endproperty
	a_supply: assert property (p_supply) else $error("supply on in suspend"); // R11

	property p_in_snap;
		@(posedge pclk) disable iff (!presetn)
		bus_rd && hit_in |=> in_snap == $past(pins_in);
	endproperty
	a_in_snap: assert property (p_in_snap) else $error("input sample lost"); // R6

	property p_hold_off;
		@(posedge pclk) disable iff (!presetn)
		state == DIOTC_TRIG_WAIT && !sel_edge |=> !acquisition_start_trigger;
	endproperty
	a_hold_off: assert property (p_hold_off) else $error("acquisition started early"); // R9

	property p_trig_single;
		@(posedge pclk) disable iff (!presetn)
		acquisition_start_trigger |=> !acquisition_start_trigger;
	endproperty
	a_trig_single: assert property (p_trig_single) else $error("start pulse too long"); // R9

	// Reset in the antecedent is sampled, unlike the disable iff; the attempt at the release edge is not judged
	property p_supply_back;
		@(posedge pclk) disable iff (!presetn)
		presetn && !usb_suspend |=> aux_supply_enable;
	endproperty
	a_supply_back: assert property (p_supply_back) else $error("supply not restored"); // R11

	c_trigger: cover property (@(posedge pclk) disable iff (!presetn)
		acquisition_start_trigger);
	c_count: cover property (@(posedge pclk) disable iff (!presetn) cnt_inc);
	c_suspend: cover property (@(posedge pclk) disable iff (!presetn)
		usb_suspend ##1 !usb_suspend);
	c_held_off: cover property (@(posedge pclk) disable iff (!presetn)
		state == DIOTC_TRIG_WAIT && !sel_edge);
	c_active: cover property (@(posedge pclk) disable iff (!presetn)
		(drive_mode == 2'h3) && (pin_oe != 12'h000));
endmodule

// ==== bench/diotc_pins.sv ====
`timescale 1ns/1ps
module diotc_pins
	import diotc_pkg::*;
(
	input wire logic [11:0] drv_val,
	input wire logic [11:0] drv_en,
	input wire logic [11:0] ext_val,
	input wire logic [11:0] ext_en,
	output logic [11:0] level
);
	// Released lines float to the on-board pull-up
	always_comb begin
		for (int i = 0; i < DIOTC_LINES; i++) begin
			level[i] = drv_en[i] ? drv_val[i] : (ext_en[i] ? ext_val[i] : 1'b1);
		end
	end
endmodule

// ==== bench/tb.sv ====
`timescale 1ns/1ps
module tb
	import diotc_pkg::*;
;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [11:0] lvl, ext_val, ext_en;
	wire [11:0] pout, poe;
	logic fpin, acq_cfg, trig, run, susp, aux;
	int failures, n_checks, pulses;

	diotc_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .wide_port_lines_in(lvl[7:0]),
		.wide_port_lines_out(pout[7:0]), .wide_port_lines_oe(poe[7:0]),
		.narrow_port_lines_in(lvl[11:8]), .narrow_port_lines_out(pout[11:8]),
		.narrow_port_lines_oe(poe[11:8]), .trigger_counter_pin(fpin),
		.acq_configured(acq_cfg), .acquisition_start_trigger(trig),
		.acq_running(run), .usb_suspend(susp), .aux_supply_enable(aux));

	diotc_pins pins (.drv_val(pout), .drv_en(poe), .ext_val(ext_val), .ext_en(ext_en),
		.level(lvl));

	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end

	task automatic end_sim;
		$display("Checks %0d, mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// One APB transfer; the wait on pready is bounded
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) begin
			failures++;
			end_sim();
		end
		// Outputs launched by the access edge settle before the caller looks
		@(posedge pclk);
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask

	task automatic do_reset;
		presetn <= 1'b0;
		cyc(6);
		presetn <= 1'b1;
	endtask

	task automatic t_reset;
		chk("oe", 32'h0, {20'h0, poe});
		apb(1'b0, DIOTC_DIR_OFS, 32'h0);
		chk("dir", 32'h0, rd);
		apb(1'b0, DIOTC_DRV_OFS, 32'h0);
		chk("drv", 32'h0, rd);
		$display("reset test done");
	endtask

	task automatic t_lines;
		apb(1'b1, DIOTC_DIR_OFS, 32'h00000FFF);
		apb(1'b1, DIOTC_OUT_OFS, 32'h000005A3);
		chk("oc_oe", 32'hA5C, {20'h0, poe});
		chk("oc_low", 32'h0, {20'h0, pout & poe});
		apb(1'b0, DIOTC_IN_OFS, 32'h0);
		chk("oc_in", 32'h5A3, rd);
		apb(1'b1, DIOTC_DRV_OFS, 32'h00000003);
		chk("ad_oe", 32'hFFF, {20'h0, poe});
		chk("ad_out", 32'h5A3, {20'h0, pout});
		apb(1'b1, DIOTC_DRV_OFS, 32'h00000001);
		chk("port_oe", 32'hAFF, {20'h0, poe});
		ext_en <= 12'hF0F;
		ext_val <= 12'h30A;
		apb(1'b1, DIOTC_DIR_OFS, 32'h000000F0);
		chk("dir_oe", 32'h0F0, {20'h0, poe});
		apb(1'b0, DIOTC_IN_OFS, 32'h0);
		chk("mix_in", 32'h3AA, rd);
		$display("lines test done");
	endtask

	task automatic pin_pulse;
		fpin <= 1'b0;
		cyc(5);
		fpin <= 1'b1;
		cyc(5);
	endtask

	task automatic t_counter;
		apb(1'b1, DIOTC_FUNC_OFS, 32'h00000011);
		repeat (5) pin_pulse();
		apb(1'b0, DIOTC_CNT_OFS, 32'h0);
		chk("count", 32'h5, rd);
		apb(1'b1, DIOTC_FUNC_OFS, 32'h00000000);
		repeat (2) pin_pulse();
		apb(1'b0, DIOTC_CNT_OFS, 32'h0);
		chk("count_trig_mode", 32'h5, rd);
		$display("counter test done");
	endtask

	task automatic watch(input int n);
		pulses = 0;
		repeat (n) begin
			@(posedge pclk);
			pulses += (trig === 1'b1) ? 1 : 0;
		end
	endtask

	task automatic t_trig(input logic rising);
		fpin <= rising;
		acq_cfg <= 1'b0;
		do_reset();
		apb(1'b1, DIOTC_FUNC_OFS, {28'h0, 1'b1, rising, 2'b10});
		watch(10);
		chk("no_cfg_pulse", 32'h0, pulses);
		chk("no_cfg_run", 32'h0, {31'h0, run});
		acq_cfg <= 1'b1;
		apb(1'b1, DIOTC_FUNC_OFS, {28'h0, 1'b1, rising, 2'b10});
		fpin <= ~rising;
		watch(10);
		chk("held_off", 32'h0, {31'h0, run});
		apb(1'b0, DIOTC_STAT_OFS, 32'h0);
		chk("stat_wait", {28'h0, ~rising, 3'b011}, rd);
		fpin <= rising;
		watch(12);
		chk("start_pulse", 32'h1, pulses);
		chk("running", 32'h1, {31'h0, run});
		$display("trigger test done");
	endtask

	task automatic t_susp;
		chk("aux_on", 32'h1, {31'h0, aux});
		susp <= 1'b1;
		cyc(3);
		chk("aux_off", 32'h0, {31'h0, aux});
		apb(1'b0, DIOTC_STAT_OFS, 32'h0);
		chk("stat_aux", 32'h0, {31'h0, rd[0]});
		susp <= 1'b0;
		cyc(3);
		chk("aux_back", 32'h1, {31'h0, aux});
		apb(1'b1, 8'h1C, 32'hFFFFFFFF);
		chk("wr_err", 32'h1, {31'h0, err});
		apb(1'b0, 8'h1C, 32'h0);
		chk("rd_err", 32'h1, {31'h0, err});
		chk("rd_zero", 32'h0, rd);
		$display("suspend test done");
	endtask

	initial begin
		failures = 0;
		n_checks = 0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		ext_val = 12'h000;
		ext_en = 12'h000;
		fpin = 1'b1;
		acq_cfg = 1'b0;
		susp = 1'b0;
		do_reset();
		t_reset();
		t_lines();
		t_counter();
		t_susp();
		t_trig(1'b1);
		t_trig(1'b0);
		end_sim();
	end
endmodule
